//--- rtl/atsc_top.sv
// Trigger, gating and channel scan control of the acquisition board
// What this block does
// - Interrupt requests pass only while enabled
// - Interrupt line binary coded, levels two to seven
// - DMA requests only while DMA enabled
// - Hardware trigger enable gates hardware sources
// - Counter two rising edge starts conversion
// - Digital input zero falling edge starts conversion
// - External gate low blocks digital triggers
// - Counter zero gets gated 100kHz tick
// - Otherwise counter zero gets inverted gate pin
// - Gate bit set: counters gated by input
// - Gate bit clear: counters run free
// - Channel write raises settle flag ten microseconds
// - Equal flag when current equals high channel
// - Conversion at high channel reloads low channel
// - Readback returns last gating control bits
// - Offsets twelve to fifteen reach timer
// - Results are unsigned twelve-bit codes
// - Channel register holds low and high nibbles
// - Channel write loads low; conversions advance
// - Status bit seven shows conversion busy
// - Result sets interrupt flag; offset eight clears
`timescale 1ns/1ps
module atsc_top
   import atsc_pkg::*;
#(
   parameter int RES_W = 12
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [3:0]       bus_addr,
   input  wire logic             bus_wr,
   input  wire logic             bus_rd,
   input  wire logic [7:0]       bus_wdata,
   output logic      [7:0]       bus_rdata,
   output logic                  bus_rvalid,
   output logic      [1:0]       pit_addr,
   output logic                  pit_wr,
   output logic                  pit_rd,
   output logic      [7:0]       pit_wdata,
   input  wire logic [7:0]       pit_rdata,
   input  wire logic             ctr2_out,
   input  wire logic             digital_in_zero,
   input  wire logic             gate_input_pin,
   input  wire logic             adc_busy,
   input  wire logic [RES_W-1:0] adc_result,
   input  wire logic             jumper_unipolar,
   input  wire logic             jumper_single_ended,
   output logic                  adc_start,
   output logic                  ctr0_clk,
   output logic                  ctr12_gate,
   output logic                  irq_req,
   output logic      [2:0]       irq_line_select,
   output logic                  dma_req,
   input  wire logic             dma_ack
);
   import atsc_pkg::*;

   function automatic logic in_timer_range(input logic [3:0] a);
      in_timer_range = (a >= OFS_PIT_BASE);
   endfunction : in_timer_range

   logic [SY_WIDTH-1:0] pins_s;
   logic [7:0]          ctrl_q;
   logic [2:0]          tgc_q;
   logic [7:0]          chan_q;
   logic [3:0]          cur_chan_q;
   logic [3:0]          tag_q;
   logic [RES_W-1:0]    result_q;
   logic                irq_flag_q;
   logic                ctr2_prev_q;
   logic                di0_prev_q;
   logic                settle_busy;
   logic [$clog2(REF_HALF_CYC+1)-1:0] ref_cnt_q;
   logic                ref_tick_q;
   atsc_conv_e          conv_q;

   logic       wr_chan;
   logic       wr_start;
   logic       wr_clear;
   logic       irq_en;
   logic       dma_en;
   logic       hw_en;
   logic       src_ctr2;
   logic       ctr2_rise;
   logic       di0_fall;
   logic       gate_open;
   logic       hw_trig;
   logic       start_go;
   logic       result_done;
   logic       equal_flag;
   logic [3:0] scan_low_channel;
   logic [3:0] scan_high_channel;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // Pin synchronisers
   atsc_sync #(
      .W       (SY_WIDTH),
      .RST_VAL (SY_WIDTH'((1 << SY_GATE) | (1 << SY_DI0))) // Pulled-up pins
   ) u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .async_in ({jumper_single_ended, jumper_unipolar, adc_busy,
                  gate_input_pin, digital_in_zero, ctr2_out}),
      .sync_out (pins_s)
   );

   // Settle timer
   atsc_settle #(
      .CYC (SETTLE_CYC)
   ) u_settle (
      .clk     (clk),
      .resetn  (resetn),
      .restart (wr_chan),
      .busy    (settle_busy)
   );

   // Write decode and field views
   assign wr_chan   = bus_wr && bus_addr == OFS_CHAN;
   assign wr_start  = bus_wr && bus_addr == OFS_DATA_LO;
   assign wr_clear  = bus_wr && bus_addr == OFS_STATUS;
   assign irq_en    = ctrl_q[CTRL_IRQ_EN];
   assign dma_en    = ctrl_q[CTRL_DMA_EN];
   assign hw_en     = ctrl_q[CTRL_HW_TRIG];
   assign src_ctr2  = ctrl_q[CTRL_TRIG_SRC];
   assign scan_low_channel  = chan_q[3:0];
   assign scan_high_channel = chan_q[7:4];
   assign equal_flag = cur_chan_q == scan_high_channel;

   // Trigger edges on synchronised pins
   assign ctr2_rise = pins_s[SY_CTR2] && !ctr2_prev_q;
   assign di0_fall  = !pins_s[SY_DI0] && di0_prev_q;
   assign gate_open = !tgc_q[TGC_EXT_GATE] || pins_s[SY_GATE];
   assign hw_trig   = hw_en && (src_ctr2 ? ctr2_rise
                                         : (di0_fall && gate_open));
   assign start_go    = conv_q == CONV_IDLE && (wr_start || hw_trig);
   assign result_done = conv_q == CONV_RUN && !pins_s[SY_BUSY];

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctr2_prev_q <= 1'b0;
         di0_prev_q  <= 1'b1;
      end
      else
      begin
         ctr2_prev_q <= pins_s[SY_CTR2];
         di0_prev_q  <= pins_s[SY_DI0];
      end
   end

   // Host-written registers
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_q <= CTRL_RESET;
         tgc_q  <= TGC_RESET;
         chan_q <= CHAN_RESET;
      end
      else if (bus_wr)
      begin
         case (bus_addr)
            OFS_CTRL: ctrl_q <= bus_wdata;
            OFS_TGC:  tgc_q  <= bus_wdata[2:0];
            OFS_CHAN: chan_q <= bus_wdata;
            default:  ;
         endcase
      end
   end

   // Conversion sequencer
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         conv_q <= CONV_IDLE;
      else
      begin
         case (conv_q)
            CONV_IDLE:
               if (start_go)
                  conv_q <= CONV_WAIT_BUSY;
            CONV_WAIT_BUSY:
               if (pins_s[SY_BUSY])
                  conv_q <= CONV_RUN;
            CONV_RUN:
               if (!pins_s[SY_BUSY])
                  conv_q <= CONV_IDLE;
            default:
               conv_q <= CONV_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         adc_start <= 1'b0;
      else
         adc_start <= start_go;
   end

   // Current channel scan
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cur_chan_q <= 4'h0;
         tag_q      <= 4'h0;
      end
      else
      begin
         if (start_go)
            tag_q <= cur_chan_q;
         if (wr_chan)
            cur_chan_q <= bus_wdata[3:0];
         else if (start_go && equal_flag)
            cur_chan_q <= scan_low_channel;
         else if (start_go)
            cur_chan_q <= cur_chan_q + 4'h1;
      end
   end

   // Result capture
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         result_q <= '0;
      else if (result_done)
         result_q <= adc_result;
   end

   // Interrupt flag, set wins over clear
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         irq_flag_q <= 1'b0;
      else if (result_done)
         irq_flag_q <= 1'b1;
      else if (wr_clear)
         irq_flag_q <= 1'b0;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_req         <= 1'b0;
         irq_line_select <= 3'h0;
      end
      else
      begin
         irq_req <= irq_flag_q && irq_en &&
                    ctrl_q[CTRL_LINE_MSB:CTRL_LINE_LSB] >= IRQ_LINE_MIN;
         irq_line_select <= ctrl_q[CTRL_LINE_MSB:CTRL_LINE_LSB];
      end
   end

   // DMA request per result
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         dma_req <= 1'b0;
      else if (!dma_en)
         dma_req <= 1'b0;
      else if (result_done)
         dma_req <= 1'b1;
      else if (dma_ack)
         dma_req <= 1'b0;
   end

   // Reference tick, held while gate pin low
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ref_cnt_q  <= '0;
         ref_tick_q <= 1'b0;
      end
      else if (pins_s[SY_GATE])
      begin
         if (ref_cnt_q == $bits(ref_cnt_q)'(REF_HALF_CYC - 1))
         begin
            ref_cnt_q  <= '0;
            ref_tick_q <= !ref_tick_q;
         end
         else
            ref_cnt_q <= ref_cnt_q + 1'b1;
      end
   end

   // Counter clock and gate outputs
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctr0_clk   <= 1'b0;
         ctr12_gate <= 1'b1;
      end
      else
      begin
         ctr0_clk <= tgc_q[TGC_CTR0_SRC] ? ref_tick_q
                                         : !pins_s[SY_GATE];
         ctr12_gate <= tgc_q[TGC_CTR12_GATE] ? pins_s[SY_DI0]
                                             : 1'b1;
      end
   end

   // Timer pass-through strobes
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pit_addr  <= 2'h0;
         pit_wr    <= 1'b0;
         pit_rd    <= 1'b0;
         pit_wdata <= 8'h00;
      end
      else
      begin
         pit_addr  <= bus_addr[1:0];
         pit_wr    <= bus_wr && in_timer_range(bus_addr);
         pit_rd    <= bus_rd && in_timer_range(bus_addr);
         pit_wdata <= bus_wdata;
      end
   end

   // Read data
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bus_rdata  <= 8'h00;
         bus_rvalid <= 1'b0;
      end
      else if (pit_rd)
      begin
         bus_rdata  <= pit_rdata;
         bus_rvalid <= 1'b1;
      end
      else if (bus_rd && !in_timer_range(bus_addr))
      begin
         bus_rvalid <= 1'b1;
         case (bus_addr)
            OFS_DATA_LO:  bus_rdata <= {result_q[3:0], tag_q};
            OFS_DATA_HI:  bus_rdata <= result_q[11:4];
            OFS_CHAN:     bus_rdata <= chan_q;
            OFS_STATUS:   bus_rdata <= {conv_q != CONV_IDLE,
                                        pins_s[SY_UNIPOL],
                                        pins_s[SY_SINGLE],
                                        irq_flag_q, cur_chan_q};
            OFS_CTRL:     bus_rdata <= ctrl_q;
            OFS_READBACK: bus_rdata <= {3'h0, settle_busy,
                                        tgc_q[TGC_EXT_GATE],
                                        equal_flag,
                                        tgc_q[TGC_CTR0_SRC],
                                        tgc_q[TGC_CTR12_GATE]};
            default:      bus_rdata <= 8'h00;
         endcase
      end
      else
         bus_rvalid <= 1'b0;
   end

   irq_gate_a: assert property (
      !irq_en |=> !irq_req)
      else $error("interrupt raised while disabled");
   irq_level_a: assert property (
      ctrl_q[CTRL_LINE_MSB:CTRL_LINE_LSB] < IRQ_LINE_MIN |=> !irq_req)
      else $error("interrupt raised on unconnected level");
   dma_gate_a: assert property (
      !dma_en |=> !dma_req)
      else $error("DMA request while DMA disabled");
   hw_off_a: assert property (
      (!hw_en && !wr_start) |=> !adc_start)
      else $error("hardware trigger while disabled");
   ctr2_trig_a: assert property (
      (conv_q == CONV_IDLE && hw_en && src_ctr2 && $rose(pins_s[SY_CTR2]))
      |=> adc_start ##1 !adc_start)
      else $error("counter edge did not start one conversion");
   di0_trig_a: assert property (
      (conv_q == CONV_IDLE && hw_en && !src_ctr2 && $fell(pins_s[SY_DI0])
       && gate_open) |=> adc_start)
      else $error("digital input edge missed");
   ext_gate_a: assert property (
      (hw_en && !src_ctr2 && tgc_q[TGC_EXT_GATE] && !pins_s[SY_GATE]
       && !wr_start) |=> !adc_start)
      else $error("gated digital trigger passed");
   wrap_a: assert property (
      (start_go && equal_flag && !wr_chan) |=> cur_chan_q == $past(chan_q[3:0]))
      else $error("scan did not reload low channel");
   chan_load_a: assert property (
      wr_chan |=> cur_chan_q == $past(bus_wdata[3:0]))
      else $error("channel write did not load low channel");
   busy_flag_a: assert property (
      start_go |=> conv_q != CONV_IDLE [*2])
      else $error("busy status not held after start");
   free_run_a: assert property (
      !tgc_q[TGC_CTR12_GATE] |=> ctr12_gate)
      else $error("counter gate dropped while free running");
   irq_clear_a: assert property (
      (wr_clear && !result_done) |=> !irq_flag_q ##1 !irq_req)
      else $error("interrupt flag not cleared");

endmodule : atsc_top

//--- rtl/atsc_pkg.sv
// Constants and types shared by the trigger and scan control block
package atsc_pkg;

   // Clock and timing
   localparam int CLK_HZ        = 25_000_000;
   localparam int SETTLE_US     = 10;
   localparam int SETTLE_CYC    = (SETTLE_US * (CLK_HZ / 1_000_000) > 0) ?
                                  SETTLE_US * (CLK_HZ / 1_000_000) : 1;
   localparam int REF_TICK_HZ   = 100_000;
   localparam int REF_HALF_CYC  = (CLK_HZ / (2 * REF_TICK_HZ) > 0) ?
                                  CLK_HZ / (2 * REF_TICK_HZ) : 1;

   // Byte offsets on the host bus
   localparam logic [3:0] OFS_DATA_LO  = 4'h0;
   localparam logic [3:0] OFS_DATA_HI  = 4'h1;
   localparam logic [3:0] OFS_CHAN     = 4'h2;
   localparam logic [3:0] OFS_STATUS   = 4'h8;
   localparam logic [3:0] OFS_CTRL     = 4'h9;
   localparam logic [3:0] OFS_TGC      = 4'hA;
   localparam logic [3:0] OFS_READBACK = 4'hB;
   localparam logic [3:0] OFS_PIT_BASE = 4'hC;

   // Acquisition control fields
   localparam int CTRL_IRQ_EN   = 7;
   localparam int CTRL_LINE_MSB = 6;
   localparam int CTRL_LINE_LSB = 4;
   localparam int CTRL_DMA_EN   = 2;
   localparam int CTRL_HW_TRIG  = 1;
   localparam int CTRL_TRIG_SRC = 0;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [2:0] IRQ_LINE_MIN = 3'h2;

   // Timer gating control fields
   localparam int TGC_EXT_GATE   = 2;
   localparam int TGC_CTR0_SRC   = 1;
   localparam int TGC_CTR12_GATE = 0;
   localparam logic [2:0] TGC_RESET = 3'h0;

   // Readback and status fields
   localparam int RB_SETTLE  = 4;
   localparam int RB_EQUAL   = 2;
   localparam int ST_BUSY    = 7;
   localparam int ST_UNIPOL  = 6;
   localparam int ST_SINGLE  = 5;
   localparam int ST_IRQ     = 4;
   localparam logic [7:0] CHAN_RESET = 8'h00;

   // Synchroniser lanes
   localparam int SY_CTR2   = 0;
   localparam int SY_DI0    = 1;
   localparam int SY_GATE   = 2;
   localparam int SY_BUSY   = 3;
   localparam int SY_UNIPOL = 4;
   localparam int SY_SINGLE = 5;
   localparam int SY_WIDTH  = 6;

   typedef enum logic [1:0] {CONV_IDLE, CONV_WAIT_BUSY, CONV_RUN} atsc_conv_e;

endpackage : atsc_pkg

//--- rtl/atsc_sync.sv
// Two-stage synchroniser for asynchronous input pins
`timescale 1ns/1ps
module atsc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         // Idle level of each pin, so no false edge follows reset
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : atsc_sync

//--- rtl/atsc_settle.sv
// Retriggerable settle timer after a channel change
`timescale 1ns/1ps
module atsc_settle #(
   parameter int CYC = 250
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic restart,
   output logic      busy
);
   logic [$clog2(CYC+1)-1:0] cnt_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // Busy for exactly CYC cycles after the last restart
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= '0;
         busy  <= 1'b0;
      end
      else if (restart)
      begin
         cnt_q <= $bits(cnt_q)'(CYC - 1);
         busy  <= 1'b1;
      end
      else if (cnt_q != '0)
         cnt_q <= cnt_q - 1'b1;
      else
         busy <= 1'b0;
   end

   settle_end_a: assert property (
      (busy && cnt_q == '0 && !restart) |=> !busy)
      else $error("settle flag outlived its count");
   settle_start_a: assert property (
      restart |=> busy && cnt_q == $bits(cnt_q)'(CYC - 1))
      else $error("settle flag not raised on channel write");
endmodule : atsc_settle

//--- tb/atsc_far_model.sv
// Converter and interval timer stand-in facing the control block
`timescale 1ns/1ps
module atsc_far_model #(
   parameter logic [7:0] PIT_VAL = 8'h5A
) (
   input  wire logic        clk,
   input  wire logic        adc_start,
   input  wire logic [11:0] next_result,
   output logic             adc_busy,
   output logic      [11:0] adc_result,
   input  wire logic [1:0]  pit_addr,
   input  wire logic        pit_wr,
   input  wire logic        pit_rd,
   input  wire logic [7:0]  pit_wdata,
   output logic      [7:0]  pit_rdata,
   output logic      [9:0]  pit_last_wr,
   output logic      [7:0]  start_count
);
   int step;

   initial
   begin
      adc_busy    = 1'b0;
      adc_result  = 12'h000;
      pit_last_wr = 10'h000;
      start_count = 8'h00;
      step        = 0;
   end

   // Busy three cycles after a start, for twenty cycles
   always @(posedge clk)
   begin
      if (adc_start === 1'b1)
         start_count <= start_count + 8'h01;
      if (adc_start === 1'b1 && step == 0)
         step <= 1;
      else if (step > 0)
         step <= (step == 23) ? 0 : step + 1;
      adc_busy <= (step >= 3 && step < 23);
      // Result churns while converting, stable before busy falls
      adc_result <= (step >= 3 && step < 22) ? ~adc_result : next_result;
   end

   // Timer registers: remember writes, answer reads by register
   always @(posedge clk)
   begin
      if (pit_wr === 1'b1)
         pit_last_wr <= {pit_addr, pit_wdata};
   end
   assign pit_rdata = (pit_rd === 1'b1) ? (PIT_VAL ^ {6'h00, pit_addr})
                                        : ~PIT_VAL;
endmodule : atsc_far_model

//--- tb/adc_trigger_scan_control_tb_top.sv
// Self-checking bench of the trigger and scan control block
`timescale 1ns/1ps
module adc_trigger_scan_control_tb_top;
   import atsc_pkg::*;
   localparam logic [7:0] PV = 8'h5A;
   logic        clk, resetn, bus_wr, bus_rd, bus_rvalid, pit_wr, pit_rd;
   logic [3:0]  bus_addr;
   logic [7:0]  bus_wdata, bus_rdata, pit_wdata, pit_rdata, start_count;
   logic [1:0]  pit_addr;
   logic        ctr2_out, digital_in_zero, gate_input_pin, adc_busy;
   logic        uni, sgl, adc_start, ctr0_clk, ctr12_gate, irq_req;
   logic        dma_req, dma_ack, flag;
   logic [2:0]  irq_line_select;
   logic [11:0] adc_result, next_result;
   logic [9:0]  pit_last_wr;
   logic [7:0]  ctrl, tgc, d;
   int          cur, lo, hi, err_count, tests_run, cycles, n, i;
   logic [27:0] tcase [9] = '{28'h030_1111, 28'h030_0010, 28'h020_0011,
                              28'h020_1110, 28'h010_1110, 28'h000_0010,
                              28'h024_0000, 28'h024_0011, 28'h020_0001};

   atsc_top dut (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .pit_addr(pit_addr),
      .pit_wr(pit_wr), .pit_rd(pit_rd), .pit_wdata(pit_wdata),
      .pit_rdata(pit_rdata), .ctr2_out(ctr2_out),
      .digital_in_zero(digital_in_zero), .gate_input_pin(gate_input_pin),
      .adc_busy(adc_busy), .adc_result(adc_result),
      .jumper_unipolar(uni), .jumper_single_ended(sgl),
      .adc_start(adc_start), .ctr0_clk(ctr0_clk), .ctr12_gate(ctr12_gate),
      .irq_req(irq_req), .irq_line_select(irq_line_select),
      .dma_req(dma_req), .dma_ack(dma_ack));

   atsc_far_model #(.PIT_VAL(PV)) far (.clk(clk), .adc_start(adc_start),
      .next_result(next_result), .adc_busy(adc_busy),
      .adc_result(adc_result), .pit_addr(pit_addr), .pit_wr(pit_wr),
      .pit_rd(pit_rd), .pit_wdata(pit_wdata), .pit_rdata(pit_rdata),
      .pit_last_wr(pit_last_wr), .start_count(start_count));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      tick(1);
      bus_addr  = a;
      bus_wdata = v;
      bus_wr    = 1'b1;
      tick(1);
      bus_wr    = 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      int k;
      tick(1);
      bus_addr = a;
      bus_rd   = 1'b1;
      tick(1);
      bus_rd   = 1'b0;
      v        = 8'hxx;
      for (k = 0; k < 3 && bus_rvalid !== 1'b1; k++)
         tick(1);
      if (bus_rvalid === 1'b1)
         v = bus_rdata;
   endtask : rd

   task automatic rdchk(input logic [3:0] a, input logic [7:0] e,
                        input string nm);
      logic [7:0] v;
      rd(a, v);
      chk(nm, {8'h00, v}, {8'h00, e});
   endtask : rdchk

   function automatic int adv();
      int t;
      t    = cur;
      cur  = (cur == hi) ? lo : (cur + 1) % 16;
      flag = 1'b1;
      return t;
   endfunction : adv

   task automatic finish_conv(input int t, input logic [11:0] r);
      logic [7:0] v;
      int k;
      v = 8'h80;
      for (k = 0; k < 30 && v[ST_BUSY] !== 1'b0; k++)
         rd(OFS_STATUS, v);
      rdchk(OFS_STATUS, {1'b0, uni, sgl, flag, 4'(cur)}, "status");
      rdchk(OFS_DATA_LO, {r[3:0], 4'(t)}, "result low");
      rdchk(OFS_DATA_HI, r[11:4], "result high");
      rdchk(OFS_READBACK, {4'h0, tgc[2], 1'(cur == hi), tgc[1:0]},
            "readback");
   endtask : finish_conv

   task automatic sw_conv(input logic [11:0] r);
      logic [7:0] v;
      int t;
      next_result = r;
      t = adv();
      wr(OFS_DATA_LO, 8'h00);
      rd(OFS_STATUS, v);
      chk("busy", 16'(v[ST_BUSY]), 16'h0001);
      finish_conv(t, r);
   endtask : sw_conv

   task automatic set_chan(input int l, input int h);
      lo  = l;
      hi  = h;
      cur = l;
      wr(OFS_CHAN, {4'(h), 4'(l)});
      rd(OFS_READBACK, d);
      chk("settle", 16'(d[RB_SETTLE]), 16'h0001);
      rdchk(OFS_CHAN, {4'(h), 4'(l)}, "chan");
      rd(OFS_STATUS, d);
      chk("current", 16'(d[3:0]), 16'(l));
      tick(230);
      rd(OFS_READBACK, d);
      chk("settle", 16'(d[RB_SETTLE]), 16'h0001);
      tick(20);
      rd(OFS_READBACK, d);
      chk("settle", 16'(d[RB_SETTLE]), 16'h0000);
   endtask : set_chan

   task automatic trig(input logic [27:0] c);
      logic [7:0] s0;
      ctrl = c[27:20];
      tgc  = {4'h0, c[19:16]};
      wr(OFS_CTRL, ctrl);
      wr(OFS_TGC, tgc);
      gate_input_pin = c[4];
      tick(5);
      s0 = start_count;
      next_result = 12'($urandom());
      ctr2_out = c[12];
      digital_in_zero = c[8];
      tick(8);
      chk("starts", 16'(start_count - s0), 16'(c[0]));
      if (c[0])
         finish_conv(adv(), next_result);
      ctr2_out = 1'b0;
      digital_in_zero = 1'b1;
      gate_input_pin = 1'b1;
      tick(5);
   endtask : trig

   initial
   begin
      {bus_wr, bus_rd, bus_addr, bus_wdata, ctr2_out, dma_ack} = '0;
      {digital_in_zero, gate_input_pin, uni, sgl} = 4'b1110;
      {resetn, flag, next_result, err_count, tests_run, cycles} = '0;
      {cur, lo, hi, ctrl, tgc} = '0;
      void'($urandom(32'h9617));
      tick(10);
      resetn = 1'b1;
      chk("gate", 16'(ctr12_gate), 16'h0001);
      chk("irq dma", 16'({irq_req, dma_req}), 16'h0000);
      rdchk(OFS_CTRL, 8'h00, "control");
      chk("ctr0 idle", 16'(ctr0_clk), 16'h0000);
      rdchk(OFS_READBACK, 8'h04, "readback");
      d = 8'($urandom());
      wr(OFS_CTRL, d);
      rdchk(OFS_CTRL, d, "control");
      tick(2);
      chk("line", 16'(irq_line_select), 16'(d[6:4]));
      wr(OFS_CTRL, 8'h00);
      for (i = 12; i < 16; i++)
      begin
         d = 8'($urandom());
         wr(4'(i), d);
         tick(1);
         chk("timer write", 16'(pit_last_wr), 16'({2'(i), d}));
         rdchk(4'(i), PV ^ 8'(i % 4), "timer read");
      end
      rdchk(OFS_TGC, 8'h00, "unmapped");
      rdchk(4'h4, 8'h00, "unmapped");
      wr(OFS_READBACK, 8'hFF);
      set_chan(14, 1);
      sw_conv(12'h000);
      sw_conv(12'hFFF);
      for (i = 0; i < 3; i++)
         sw_conv(12'($urandom()));
      {uni, sgl} = 2'b01;
      set_chan($urandom_range(15, 0), $urandom_range(15, 0));
      for (i = 0; i < 4; i++)
         sw_conv(12'($urandom()));
      for (i = 0; i < 9; i++)
         trig(tcase[i]);
      wr(OFS_CTRL, 8'h00);
      wr(OFS_TGC, 8'h00);
      tick(5);
      chk("ctr0 inv", 16'(ctr0_clk), 16'h0000);
      gate_input_pin = 1'b0;
      tick(5);
      chk("ctr0 inv", 16'(ctr0_clk), 16'h0001);
      digital_in_zero = 1'b0;
      tick(5);
      chk("free gate", 16'(ctr12_gate), 16'h0001);
      wr(OFS_TGC, 8'h03);
      tick(5);
      chk("di gate", 16'(ctr12_gate), 16'h0000);
      digital_in_zero = 1'b1;
      tick(5);
      chk("di gate", 16'(ctr12_gate), 16'h0001);
      gate_input_pin = 1'b1;
      tick(5);
      n = 0;
      repeat (300)
      begin
         d[0] = ctr0_clk;
         tick(1);
         n += (ctr0_clk !== d[0]);
      end
      chk("ref runs", 16'(n >= 2 && n <= 3), 16'h0001);
      gate_input_pin = 1'b0;
      tick(5);
      d[0] = ctr0_clk;
      tick(300);
      chk("ref stops", 16'(ctr0_clk), 16'(d[0]));
      gate_input_pin = 1'b1;
      tgc = 8'h00;
      wr(OFS_TGC, tgc);
      for (i = 0; i < 9; i++)
      begin
         ctrl = (i == 8) ? 8'h30 : {1'b1, 3'(i), 4'h0};
         wr(OFS_CTRL, ctrl);
         wr(OFS_STATUS, 8'h00);
         flag = 1'b0;
         sw_conv(12'($urandom()));
         chk("irq", 16'(irq_req), 16'(i >= 2 && i < 8));
         chk("line", 16'(irq_line_select), 16'(ctrl[6:4]));
      end
      wr(OFS_CTRL, 8'hA0);
      tick(1);
      chk("irq set", 16'(irq_req), 16'h0001);
      wr(OFS_STATUS, 8'h00);
      flag = 1'b0;
      tick(2);
      chk("irq clear", 16'(irq_req), 16'h0000);
      for (i = 0; i < 2; i++)
      begin
         wr(OFS_CTRL, i ? 8'h00 : 8'h04);
         sw_conv(12'($urandom()));
         chk("dma", 16'(dma_req), 16'(i == 0));
         dma_ack = 1'b1;
         tick(1);
         dma_ack = 1'b0;
         tick(2);
         chk("dma ack", 16'(dma_req), 16'h0000);
      end
      report_and_stop();
   end
endmodule : adc_trigger_scan_control_tb_top
